/* File: hdl/hkpos_pkg.sv */
// Package with constants, register map and carrier types for the hook position block.
package hkpos_pkg;

  // ==========================================================================
  // Position widths and limits
  // ==========================================================================
  localparam int          POS_W        = 25;             // Holds +/-8388608.
  localparam logic [24:0] POS_MAX      = 25'h0800000;    // +8388608.
  localparam logic [24:0] POS_MIN      = 25'h1800000;    // -8388608.
  localparam logic [15:0] BUS_MAX      = 16'h7fff;       // +32767.
  localparam logic [15:0] BUS_MIN      = 16'h8001;       // -32767.
  localparam logic [15:0] SCALE_RESET  = 16'h0064;       // Pulses per unit after reset.
  localparam logic [24:0] HOME_RESET   = 25'h0000000;    // Home position after reset.

  // ==========================================================================
  // APB register offsets (byte addresses)
  // ==========================================================================
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_SCALE    = 8'h04;
  localparam logic [7:0] ADDR_HOME     = 8'h08;
  localparam logic [7:0] ADDR_HREF     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS   = 8'h10;
  localparam logic [7:0] ADDR_POS      = 8'h14;
  localparam logic [7:0] ADDR_BUSPOS   = 8'h18;
  localparam logic [7:0] ADDR_RETAIN   = 8'h1c;

  // ==========================================================================
  // Control register field positions
  // ==========================================================================
  localparam int CTRL_LOCAL_BIT   = 0;   // 1 = local stand-alone location.
  localparam int CTRL_HREQ_EN_BIT = 1;   // Homing request source selected.
  localparam int CTRL_ACK_EN_BIT  = 2;   // Homing ack source selected.
  localparam int CTRL_ACK_RST_BIT = 3;   // Ack mode set to reset.
  localparam int CTRL_APPL_BIT    = 4;   // Command word bit 1 position load.
  localparam logic [4:0] CTRL_RESET = 5'h00;

  // Homing states, one-hot.
  typedef enum logic [2:0] {
    HK_IDLE = 3'b001,
    HK_RUN  = 3'b010,
    HK_DONE = 3'b100
  } hkpos_state_e;

  // Motion command to the speed control.
  typedef struct packed {
    logic run;      // Homing motion requested.
    logic reverse;  // Direction of travel.
  } hkpos_motion_s;

endpackage

/* File: hdl/hkpos_top.sv */
// Hook position accumulator with homing and APB register access.
`timescale 1ns/1ps

module hkpos_top #(
  parameter int SCALE_W = 16
) (
  // Clock and reset.
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst,
  // APB slave.
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // Encoder and homing pins.
  input  wire logic        i_enc_a,
  input  wire logic        i_enc_b,
  input  wire logic        i_homing_req,
  input  wire logic        i_homing_ack,
  // Retained storage: value restored at power-up and its valid flag.
  input  wire logic [24:0] i_retain_pos,
  input  wire logic        i_retain_valid,
  output logic [24:0]      o_retain_pos,
  // Drive side outputs.
  output logic             o_homing_active,
  output logic             o_homing_done,
  output logic             o_motion_run,
  output logic             o_motion_reverse,
  output logic             o_coupled_interlock_en,
  output logic [15:0]      o_bus_position
);

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  // Two stages per pin; only the second stage is read by logic.
  logic [3:0] sync1_q;   // First stage.
  logic [3:0] sync2_q;   // Second stage.
  logic [3:0] pins;      // Raw pins gathered.
  assign pins = {i_homing_ack, i_homing_req, i_enc_b, i_enc_a};

  // Double flop each pin through one generate loop.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge i_ref_clk or posedge i_rst) begin
        if (i_rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= pins[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  logic enc_a;     // Synchronised encoder A.
  logic enc_b;     // Synchronised encoder B.
  logic hreq_pin;  // Synchronised homing request.
  logic hack_pin;  // Synchronised homing acknowledge.
  assign enc_a    = sync2_q[0];
  assign enc_b    = sync2_q[1];
  assign hreq_pin = sync2_q[2];
  assign hack_pin = sync2_q[3];

  // ==========================================================================
  // Registers
  // ==========================================================================
  logic [4:0]         ctrl_q;    // Control bits.
  logic [SCALE_W-1:0] scale_q;   // Pulses per position unit.
  logic [24:0]        home_q;    // Home position value.
  logic [15:0]        href_q;    // Signed homing speed reference.
  logic               cmd_dir_valid_q; // Start command carries a direction.
  logic               cmd_dir_rev_q;   // Direction from the start command.
  logic               appl_load; // One-cycle load request from bus write.

  logic apb_wr;   // Write access phase.
  logic apb_rd;   // Read access phase.
  assign apb_wr = i_psel & i_penable & i_pwrite;
  assign apb_rd = i_psel & i_penable & ~i_pwrite;

  // Fields of the control register.
  logic local_sel;
  logic hreq_sel;
  logic ack_sel;
  logic ack_rst;
  assign local_sel = ctrl_q[hkpos_pkg::CTRL_LOCAL_BIT];
  assign hreq_sel  = ctrl_q[hkpos_pkg::CTRL_HREQ_EN_BIT];
  assign ack_sel   = ctrl_q[hkpos_pkg::CTRL_ACK_EN_BIT];
  assign ack_rst   = ctrl_q[hkpos_pkg::CTRL_ACK_RST_BIT];

  // command word load
  // Writing the command bit as one makes a single load pulse; the bit is not stored.
  assign appl_load = apb_wr && (i_paddr == hkpos_pkg::ADDR_CTRL)
                     && i_pwdata[hkpos_pkg::CTRL_APPL_BIT];

  // saturate loaded values
  // The 25-bit carrier reaches past the position span, so values from software
  // and from the retained store are clipped on the way in.
  function automatic logic [24:0] pos_sat(input logic [24:0] v);
    if ($signed(v) > $signed(hkpos_pkg::POS_MAX)) begin
      return hkpos_pkg::POS_MAX;
    end else if ($signed(v) < $signed(hkpos_pkg::POS_MIN)) begin
      return hkpos_pkg::POS_MIN;
    end else begin
      return v;
    end
  endfunction

  // Software writes to configuration registers.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q          <= hkpos_pkg::CTRL_RESET;
      scale_q         <= SCALE_W'(hkpos_pkg::SCALE_RESET);
      home_q          <= hkpos_pkg::HOME_RESET;
      href_q          <= 16'h0000;
      cmd_dir_valid_q <= 1'b0;
      cmd_dir_rev_q   <= 1'b0;
    end else if (apb_wr) begin
      case (i_paddr)
        hkpos_pkg::ADDR_CTRL: begin
          ctrl_q          <= {1'b0, i_pwdata[3:0]};
          cmd_dir_valid_q <= i_pwdata[8];
          cmd_dir_rev_q   <= i_pwdata[9];
        end
        hkpos_pkg::ADDR_SCALE: scale_q <= i_pwdata[SCALE_W-1:0];
        hkpos_pkg::ADDR_HOME:  home_q  <= pos_sat(i_pwdata[24:0]);
        hkpos_pkg::ADDR_HREF:  href_q  <= i_pwdata[15:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // Quadrature decoder
  // ==========================================================================
  logic enc_a_q;  // Previous A.
  logic enc_b_q;  // Previous B.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      enc_a_q <= 1'b0;
      enc_b_q <= 1'b0;
    end else begin
      enc_a_q <= enc_a;
      enc_b_q <= enc_b;
    end
  end

  // quadrature direction
  // Any single-edge change is one count; A leading B counts up. Double changes
  // are ignored as glitches, since the direction cannot be known.
  logic step;
  logic step_up;
  assign step    = (enc_a ^ enc_a_q) ^ (enc_b ^ enc_b_q);
  assign step_up = enc_a ^ enc_b_q;

  // ==========================================================================
  // Pulse prescaler
  // ==========================================================================
  // pulse scaling
  // A signed residue counts pulses; a full scale worth becomes one unit.
  logic signed [SCALE_W:0] frac_q;
  logic                    unit_up;
  logic                    unit_dn;
  logic                    pos_load;
  logic [24:0]             load_val;
  logic signed [SCALE_W:0] scale_s;
  assign scale_s = $signed({1'b0, scale_q});
  assign unit_up = step && step_up && (frac_q + 1 >= scale_s) && (scale_q != '0);
  assign unit_dn = step && !step_up && (frac_q - 1 <= -scale_s) && (scale_q != '0);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      frac_q <= '0;
    end else if (pos_load) begin
      frac_q <= '0;
    end else if (unit_up || unit_dn) begin
      frac_q <= '0;
    end else if (step) begin
      frac_q <= step_up ? frac_q + 1'b1 : frac_q - 1'b1;
    end
  end

  // ==========================================================================
  // Homing sequencer
  // ==========================================================================
  hkpos_pkg::hkpos_state_e state_q;
  hkpos_pkg::hkpos_motion_s motion_q;
  logic homing_req;
  assign homing_req = hreq_sel & hreq_pin & local_sel;

  // Manual reset: request selected with ack mode reset, in local location.
  logic manual_load;
  assign manual_load = local_sel & hreq_sel & ack_rst;

  // operator ends manual reset
  // Load repeats while the mode stays on; clearing the bits ends it.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= hkpos_pkg::HK_IDLE;
    end else begin
      case (state_q)
        hkpos_pkg::HK_IDLE: begin
          if (homing_req && !ack_rst) begin
            state_q <= hkpos_pkg::HK_RUN;
          end
        end
        hkpos_pkg::HK_RUN: begin
          if (!homing_req) begin
            state_q <= hkpos_pkg::HK_IDLE;
          end else if (ack_sel && hack_pin) begin
            state_q <= hkpos_pkg::HK_DONE;
          end
        end
        hkpos_pkg::HK_DONE: begin
          // Done stands until the request drops.
          if (!homing_req) begin
            state_q <= hkpos_pkg::HK_IDLE;
          end
        end
        default: state_q <= hkpos_pkg::HK_IDLE;
      endcase
    end
  end

  logic homing_finish;
  assign homing_finish = (state_q == hkpos_pkg::HK_RUN) && homing_req && ack_sel && hack_pin;

  // direction choice
  // Start command direction wins; otherwise the sign of the speed reference.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      motion_q <= '0;
    end else begin
      motion_q.run     <= (state_q == hkpos_pkg::HK_RUN) && !homing_finish && homing_req;
      motion_q.reverse <= cmd_dir_valid_q ? cmd_dir_rev_q : href_q[15];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_homing_active <= 1'b0;
      o_homing_done   <= 1'b0;
    end else begin
      o_homing_active <= homing_req;
      o_homing_done   <= (state_q == hkpos_pkg::HK_DONE) || homing_finish;
    end
  end

  assign o_motion_run     = motion_q.run;
  assign o_motion_reverse = motion_q.reverse;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_coupled_interlock_en <= 1'b0;
    end else begin
      o_coupled_interlock_en <= !local_sel;
    end
  end

  // ==========================================================================
  // Actual position
  // ==========================================================================
  // load on completion, loads share the home value
  assign pos_load = homing_finish | appl_load | manual_load;
  assign load_val = home_q;

  logic [24:0] pos_q;         // Actual position, signed.
  logic        restored_q;    // Retained value taken once after reset.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      pos_q      <= '0;
      restored_q <= 1'b0;
    end else if (!restored_q) begin
      restored_q <= 1'b1;
      if (i_retain_valid) begin
        pos_q <= pos_sat(i_retain_pos);
      end
    end else if (pos_load) begin
      pos_q <= load_val;
    end else if (unit_up && (pos_q != hkpos_pkg::POS_MAX)) begin
      pos_q <= pos_q + 25'h0000001;
    end else if (unit_dn && (pos_q != hkpos_pkg::POS_MIN)) begin
      pos_q <= pos_q - 25'h0000001;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_retain_pos <= '0;
    end else begin
      o_retain_pos <= pos_q;
    end
  end

  logic [15:0] bus_pos;
  always_comb begin
    if ($signed(pos_q) > $signed({{9{1'b0}}, hkpos_pkg::BUS_MAX})) begin
      bus_pos = hkpos_pkg::BUS_MAX;
    end else if ($signed(pos_q) < $signed({{9{1'b1}}, hkpos_pkg::BUS_MIN})) begin
      bus_pos = hkpos_pkg::BUS_MIN;
    end else begin
      bus_pos = pos_q[15:0];
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_bus_position <= '0;
    end else begin
      o_bus_position <= bus_pos;
    end
  end

  // ==========================================================================
  // APB read path
  // ==========================================================================
  // Zero wait state; unmapped addresses read zero and flag an error.
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata  <= '0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel & ~i_penable;
      o_pslverr <= 1'b0;
      o_prdata  <= '0;
      if (i_psel && !i_penable) begin
        case (i_paddr)
          hkpos_pkg::ADDR_CTRL:   o_prdata <= {22'h0, cmd_dir_rev_q, cmd_dir_valid_q,
                                               4'h0, ctrl_q[3:0]};
          hkpos_pkg::ADDR_SCALE:  o_prdata <= 32'(scale_q);
          hkpos_pkg::ADDR_HOME:   o_prdata <= {7'h0, home_q};
          hkpos_pkg::ADDR_HREF:   o_prdata <= {16'h0, href_q};
          hkpos_pkg::ADDR_STATUS: o_prdata <= {29'h0, motion_q.run, o_homing_done,
                                               o_homing_active};
          hkpos_pkg::ADDR_POS:    o_prdata <= {{7{pos_q[24]}}, pos_q};
          hkpos_pkg::ADDR_BUSPOS: o_prdata <= {{16{bus_pos[15]}}, bus_pos};
          hkpos_pkg::ADDR_RETAIN: o_prdata <= {31'h0, restored_q};
          default:                o_pslverr <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  sequence ack_seen;
    (state_q == hkpos_pkg::HK_RUN) && homing_req && ack_sel && hack_pin;
  endsequence

  home_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ack_seen and restored_q |=> pos_q == $past(home_q))
    else $error("Home value not loaded at homing end.");
  done_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ack_seen |=> o_homing_done && (state_q == hkpos_pkg::HK_DONE))
    else $error("Done flag missing after acknowledge.");
  stop_motor_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    ack_seen |=> !o_motion_run)
    else $error("Motor still runs after acknowledge.");
  local_only_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !local_sel |=> !o_homing_active && !o_motion_run)
    else $error("Homing outside local location.");
  active_flag_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_homing_active == $past(hreq_sel & hreq_pin & local_sel))
    else $error("Homing active flag wrong.");
  dir_pick_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    !cmd_dir_valid_q && $stable(cmd_dir_valid_q) |=> o_motion_reverse == $past(href_q[15]))
    else $error("Direction not from reference sign.");
  bus_clamp_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $signed(o_bus_position) >= -16'sd32767)
    else $error("Bus word below lower limit.");
  pos_range_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $signed(pos_q) <= $signed(hkpos_pkg::POS_MAX) && $signed(pos_q) >= $signed(hkpos_pkg::POS_MIN))
    else $error("Position out of range.");
  cmd_load_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    appl_load && restored_q |=> pos_q == $past(home_q))
    else $error("Command word load failed.");
  count_up_a: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    unit_up && !pos_load && restored_q && pos_q != hkpos_pkg::POS_MAX |=> pos_q == $past(pos_q) + 25'h1)
    else $error("Forward unit not counted.");

endmodule

/* File: testbench/hkpos_encoder_model.sv */
// Model of the motor shaft quadrature encoder and the homing limit switch.
`timescale 1ns/1ps

module hkpos_encoder_model (
  // Clock.
  input  wire logic i_ref_clk,
  // Encoder and switch pins.
  output logic      o_enc_a,
  output logic      o_enc_b,
  output logic      o_homing_ack
);
  // =========================================================================
  // Quadrature phase
  // =========================================================================
  logic [1:0] phase_q;  // Shaft phase, one step per single pin change.

  // Pins start at rest with the switch open.
  initial begin
    phase_q      = 2'h0;
    o_enc_a      = 1'b0;
    o_enc_b      = 1'b0;
    o_homing_ack = 1'b0;
  end

  // Turns the shaft by a number of single edges; A leads B when forward.
  // Only one pin changes per step, so the block never sees a double change.
  task automatic move(input int edges, input logic rev, input int gap);
    repeat (edges) begin
      phase_q = rev ? phase_q - 2'h1 : phase_q + 2'h1;
      @(posedge i_ref_clk);
      o_enc_a <= phase_q[1] ^ phase_q[0];
      o_enc_b <= phase_q[1];
      repeat (gap) @(posedge i_ref_clk);
    end
  endtask

  // Closes or opens the homing switch just after a clock edge.
  task automatic set_ack(input logic level);
    @(posedge i_ref_clk);
    o_homing_ack <= level;
  endtask
endmodule

/* File: testbench/hook_position_homing_bench.sv */
// Self-checking bench for the hook position block over its APB registers.
`timescale 1ns/1ps

`define check_eq(what, exp, got) begin tests_run++; if ((got) !== (exp)) begin mismatches++; \
  $display("MISMATCH %s expected %h seen %h", what, exp, got); end end

module hook_position_homing_bench;
  // =========================================================================
  // Signals
  // =========================================================================
  logic        clk, rst, psel, penable, pwrite, hreq, enc_a, enc_b, ack;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err;
  logic [24:0] retain_pos;
  logic        active, done, run, rev, ilock;
  logic        retain_valid;  // Stored position marked valid at power-up.
  logic [15:0] bus_pos;
  int          mismatches = 0;
  int          tests_run  = 0;
  logic [24:0] homes [5] = '{25'h0010000, 25'h1ff0000, 25'h0000100,
                             hkpos_pkg::POS_MAX, hkpos_pkg::POS_MIN};
  logic [15:0] clamps [5] = '{16'h7fff, 16'h8001, 16'h0100,
                              hkpos_pkg::BUS_MAX, hkpos_pkg::BUS_MIN};

  // 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  hkpos_top hkpos_top_i (
    .i_ref_clk(clk), .i_rst(rst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
    .o_pready(pready), .o_pslverr(pslverr), .i_enc_a(enc_a), .i_enc_b(enc_b),
    .i_homing_req(hreq), .i_homing_ack(ack), .i_retain_pos(25'h0000123),
    .i_retain_valid(retain_valid), .o_retain_pos(retain_pos), .o_homing_active(active),
    .o_homing_done(done), .o_motion_run(run), .o_motion_reverse(rev),
    .o_coupled_interlock_en(ilock), .o_bus_position(bus_pos)
  );

  hkpos_encoder_model hkpos_encoder_model_i (
    .i_ref_clk(clk), .o_enc_a(enc_a), .o_enc_b(enc_b), .o_homing_ack(ack)
  );

  // =========================================================================
  // APB master
  // =========================================================================
  // One transfer; a dead slave is caught by the watchdog, not by this task.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd  = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Reads a register and compares the word.
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    `check_eq("read data", exp, rd)
  endtask

  // Waits long enough for a pin change to pass the synchroniser and counter.
  task automatic settle();
    repeat (8) @(posedge clk);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // Watchdog: the sequence needs a few hundred cycles at most.
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end

  // =========================================================================
  // Test sequence
  // =========================================================================
  initial begin
    rst          = 1'b1;
    psel         = 1'b0;
    penable      = 1'b0;
    pwrite       = 1'b0;
    paddr        = 8'h00;
    pwdata       = 32'h0;
    hreq         = 1'b0;
    retain_valid = 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000123);
    rd_chk(hkpos_pkg::ADDR_SCALE, 32'h00000064);
    rd_chk(hkpos_pkg::ADDR_CTRL, 32'h00000000);
    `check_eq("interlock remote", 1'b1, ilock)
    apb(1'b0, 8'h20, 32'h0);
    `check_eq("unmapped error", 1'b1, err)
    `check_eq("unmapped data", 32'h0, rd)
    // Scale of four edges per unit, forward then reverse travel.
    apb(1'b1, hkpos_pkg::ADDR_SCALE, 32'h00000004);
    hkpos_encoder_model_i.move(8, 1'b0, 3);
    settle();
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000125);
    hkpos_encoder_model_i.move(12, 1'b1, 3);
    settle();
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000122);
    `check_eq("retained copy", 25'h0000122, retain_pos)
    // Command bit loads, including both ends of the internal range.
    for (int i = 0; i < 5; i++) begin
      apb(1'b1, hkpos_pkg::ADDR_HOME, {7'h0, homes[i]});
      apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h00000010);
      settle();
      rd_chk(hkpos_pkg::ADDR_POS, {{7{homes[i][24]}}, homes[i]});
      `check_eq("bus position", clamps[i], bus_pos)
    end
    // Homing refused outside the local location.
    apb(1'b1, hkpos_pkg::ADDR_HOME, 32'h00000032);
    apb(1'b1, hkpos_pkg::ADDR_HREF, 32'h0000fffb);
    apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h00000006);
    hreq <= 1'b1;
    settle();
    `check_eq("active remote", 1'b0, active)
    `check_eq("run remote", 1'b0, run)
    apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h00000007);
    settle();
    `check_eq("active local", 1'b1, active)
    `check_eq("run local", 1'b1, run)
    `check_eq("interlock local", 1'b0, ilock)
    `check_eq("reverse from ref", 1'b1, rev)
    apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h00000107);
    settle();
    `check_eq("forward by start", 1'b0, rev)
    hkpos_encoder_model_i.set_ack(1'b1);
    for (int n = 0; n < 30 && done !== 1'b1; n++) @(posedge clk);
    `check_eq("done", 1'b1, done)
    `check_eq("stopped", 1'b0, run)
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000032);
    rd_chk(hkpos_pkg::ADDR_STATUS, 32'h00000003);
    hreq <= 1'b0;
    hkpos_encoder_model_i.set_ack(1'b0);
    settle();
    `check_eq("done cleared", 1'b0, done)
    // Manual reset holds the home value while the shaft turns.
    apb(1'b1, hkpos_pkg::ADDR_HOME, 32'h00000007);
    apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h0000000b);
    hreq <= 1'b1;
    settle();
    hkpos_encoder_model_i.move(6, 1'b0, 2);
    settle();
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000007);
    hreq <= 1'b0;
    apb(1'b1, hkpos_pkg::ADDR_CTRL, 32'h00000001);
    settle();
    hkpos_encoder_model_i.move(4, 1'b0, 2);
    settle();
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000008);
    // A power cycle with no valid stored value starts from zero.
    retain_valid <= 1'b0;
    rst          <= 1'b1;
    repeat (2) @(posedge clk);
    rst          <= 1'b0;
    rd_chk(hkpos_pkg::ADDR_POS, 32'h00000000);
    rd_chk(hkpos_pkg::ADDR_RETAIN, 32'h00000001);
    conclude();
  end
endmodule
